// ---- frc_pkg.sv ----
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package frc_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned TICK_US = 2;
    localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int unsigned COUNT_W = 16;
    localparam int unsigned REG8_W = 8;
    localparam int unsigned CMP3_BIT = 5;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COMPARE_RST = 16'hFFFF;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;
endpackage : frc_pkg

// ---- tick_gen.sv ----
`timescale 1ns/10ps
// Prescaler giving one pulse per counter tick
module tick_gen import frc_pkg::*; #(
    parameter int unsigned DIV = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    localparam int unsigned PW = $clog2(DIV);
    logic [PW-1:0] cnt_r;

    // Divide clock down; tick on terminal count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (cnt_r == PW'(DIV - 1)) begin
            cnt_r <= '0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule : tick_gen

// ---- free_run_output_compare.sv ----
`timescale 1ns/10ps
module free_run_output_compare import frc_pkg::*; #(
    parameter int unsigned DIV = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Compare value load
    input wire logic compare_wr,
    input wire logic [15:0] compare_wdata,
    // Mask register write (full byte)
    input wire logic mask_wr,
    input wire logic [7:0] mask_wdata,
    // Flag register write-one-to-clear
    input wire logic flags_wr,
    input wire logic [7:0] flags_wdata,
    // Processor global interrupt mask (1 = masked)
    input wire logic global_mask,
    // Status
    output logic [15:0] free_run_count,
    output logic [15:0] compare_three_value,
    output logic [7:0] timer_enable_mask,
    output logic [7:0] timer_event_flags,
    output logic compare_match,
    output logic irq_req
);
    // Internal strobes
    logic tick;
    logic match_nxt;
    // Cycles since the last tick, watched by the spacing check
    logic [31:0] since_tick_r;

    //------------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------------
    // Counter value after the next tick, wrapping from the top to zero
    function automatic logic [15:0] count_after(input logic [15:0] v);
        return v + 16'h0001;
    endfunction : count_after

    //------------------------------------------------------------------------
    // Time base
    //------------------------------------------------------------------------
    // Prescaler: one tick every DIV clocks
    tick_gen #(.DIV(DIV)) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(tick)
    );

    // Counter advances each tick and wraps naturally
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            free_run_count <= COUNT_RST;
        end else if (tick) begin
            free_run_count <= count_after(free_run_count);
        end
    end

    //------------------------------------------------------------------------
    // Compare register
    //------------------------------------------------------------------------
    // Compare register, writable at any time
    // A new value simply reschedules the next match
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_three_value <= COMPARE_RST;
        end else if (compare_wr) begin
            compare_three_value <= compare_wdata;
        end
    end

    //------------------------------------------------------------------------
    // Match detection
    //------------------------------------------------------------------------
    // One event per counter value: only on the tick that lands on it.
    // A compare value equal to the current count is already passed, so
    // it waits for a full wrap of the counter.
    assign match_nxt = tick &&
        (count_after(free_run_count) == compare_three_value);

    // Registered so the one-cycle pulse falls in the first cycle the counter shows the value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_match <= 1'b0;
        end else begin
            compare_match <= match_nxt;
        end
    end

    //------------------------------------------------------------------------
    // Mask and flag registers
    //------------------------------------------------------------------------
    // Mask register, whole byte; only the channel three bit acts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_enable_mask <= MASK_RST;
        end else if (mask_wr) begin
            timer_enable_mask <= mask_wdata;
        end
    end

    // Flags: set wins over write-one clear; zeros leave bits alone
    // A clear landing on a match is dropped, so no event goes missing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_event_flags <= FLAGS_RST;
        end else begin
            for (int i = 0; i < REG8_W; i++) begin
                if (i == CMP3_BIT && compare_match) begin
                    timer_event_flags[i] <= 1'b1;
                end else if (flags_wr && flags_wdata[i]) begin
                    timer_event_flags[i] <= 1'b0;
                end
            end
        end
    end

    //------------------------------------------------------------------------
    // Interrupt request
    //------------------------------------------------------------------------
    // Request lags its cause by one cycle; the global mask is a level
    // and gates the request without touching the flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= timer_event_flags[CMP3_BIT] &&
                timer_enable_mask[CMP3_BIT] && !global_mask;
        end
    end

    //------------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------------
    // Spacing counter for the tick check; starts one below zero so that
    // the first interval after reset reads the same as all later ones
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            since_tick_r <= 32'hFFFF_FFFF;
        end else if (tick) begin
            since_tick_r <= 32'h0000_0000;
        end else begin
            since_tick_r <= since_tick_r + 32'h0000_0001;
        end
    end

    // Time base and counter
    chk_tick_gap: assert property (@(posedge clk) disable iff (rst)
        tick == (since_tick_r == DIV - 1))
        else $error("tick spacing differs from the divider");
    chk_count_tick: assert property (@(posedge clk) disable iff (rst)
        tick |=> free_run_count == count_after($past(free_run_count)))
        else $error("counter did not advance on tick");
    chk_count_hold: assert property (@(posedge clk) disable iff (rst)
        !tick |=> $stable(free_run_count))
        else $error("counter moved without tick");

    // Match detection
    chk_match_eq: assert property (@(posedge clk) disable iff (rst)
        compare_match |-> free_run_count == $past(compare_three_value))
        else $error("match without equality");
    chk_match_tick: assert property (@(posedge clk) disable iff (rst)
        compare_match |-> $past(tick))
        else $error("match away from a tick");
    chk_match_pulse: assert property (@(posedge clk) disable iff (rst)
        compare_match |=> !compare_match)
        else $error("match lasted more than one cycle");

    // Compare and mask registers
    chk_cmp_load: assert property (@(posedge clk) disable iff (rst)
        compare_wr |=> compare_three_value == $past(compare_wdata))
        else $error("compare write did not land");
    chk_cmp_hold: assert property (@(posedge clk) disable iff (rst)
        !compare_wr |=> $stable(compare_three_value))
        else $error("compare value moved without a write");
    chk_mask_load: assert property (@(posedge clk) disable iff (rst)
        mask_wr |=> timer_enable_mask == $past(mask_wdata))
        else $error("mask write did not land");
    chk_mask_hold: assert property (@(posedge clk) disable iff (rst)
        !mask_wr |=> $stable(timer_enable_mask))
        else $error("mask moved without a write");

    // Event flags
    chk_match_sets: assert property (@(posedge clk) disable iff (rst)
        compare_match |=> timer_event_flags[CMP3_BIT])
        else $error("flag not set by match");
    chk_flag_clear: assert property (@(posedge clk) disable iff (rst)
        flags_wr && flags_wdata[CMP3_BIT] && !compare_match
        |=> !timer_event_flags[CMP3_BIT])
        else $error("flag not cleared by write one");
    chk_flag_zero: assert property (@(posedge clk) disable iff (rst)
        timer_event_flags[CMP3_BIT] && !(flags_wr && flags_wdata[CMP3_BIT])
        |=> timer_event_flags[CMP3_BIT])
        else $error("flag lost without clear");
    chk_flag_others: assert property (@(posedge clk) disable iff (rst)
        timer_event_flags == 8'h00 ||
        timer_event_flags == (8'h01 << CMP3_BIT))
        else $error("flag outside channel three set");

    // Interrupt request
    chk_irq_cause: assert property (@(posedge clk) disable iff (rst)
        irq_req |-> $past(timer_event_flags[CMP3_BIT]) &&
        $past(timer_enable_mask[CMP3_BIT]) && !$past(global_mask))
        else $error("request without cause");
    chk_irq_stop: assert property (@(posedge clk) disable iff (rst)
        mask_wr && !mask_wdata[CMP3_BIT] |=> ##1 !irq_req)
        else $error("request after enable cleared");
    chk_irq_rise: assert property (@(posedge clk) disable iff (rst)
        timer_event_flags[CMP3_BIT] && timer_enable_mask[CMP3_BIT] &&
        !global_mask |=> irq_req)
        else $error("recognised event gave no request");
    chk_irq_global: assert property (@(posedge clk) disable iff (rst)
        global_mask |=> !irq_req)
        else $error("request while globally masked");
    chk_irq_fall: assert property (@(posedge clk) disable iff (rst)
        !timer_event_flags[CMP3_BIT] |=> !irq_req)
        else $error("request without a pending flag");

    //------------------------------------------------------------------------
    // Covers
    //------------------------------------------------------------------------
    // Main scenarios: match, request, set against clear, wrap, stop
    cov_match: cover property (@(posedge clk) disable iff (rst)
        compare_match);
    cov_irq: cover property (@(posedge clk) disable iff (rst)
        $rose(irq_req));
    cov_set_clear: cover property (@(posedge clk) disable iff (rst)
        compare_match && flags_wr && flags_wdata[CMP3_BIT]);
    cov_wrap: cover property (@(posedge clk) disable iff (rst)
        tick && free_run_count == 16'hFFFF);
    cov_irq_stop: cover property (@(posedge clk) disable iff (rst)
        $fell(irq_req));
endmodule : free_run_output_compare

// ---- isr_model.sv ----
`timescale 1ns/10ps
// Processor side: loads compare, clears the flag, services the request
module isr_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench commands
    input wire logic load,
    input wire logic [15:0] load_val,
    input wire logic clr,
    input wire logic svc_en,
    // Device side
    input wire logic irq_req,
    input wire logic [15:0] compare_three_value,
    output logic compare_wr,
    output logic [15:0] compare_wdata,
    output logic flags_wr,
    output logic [7:0] flags_wdata
);
    logic busy_r;
    // One service per request; idle data lines toggle so stale values fail
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
            compare_wr <= 1'b0;
            flags_wr <= 1'b0;
            compare_wdata <= 16'h0000;
            flags_wdata <= 8'h00;
        end else begin
            compare_wr <= 1'b0;
            flags_wr <= 1'b0;
            compare_wdata <= ~compare_wdata;
            flags_wdata <= ~flags_wdata;
            if (!irq_req) busy_r <= 1'b0;
            if (svc_en && irq_req && !busy_r) begin
                busy_r <= 1'b1;
                compare_wr <= 1'b1;
                compare_wdata <= compare_three_value + 16'h01F4;
                flags_wr <= 1'b1;
                flags_wdata <= 8'h20;
            end else if (load) begin
                compare_wr <= 1'b1;
                compare_wdata <= load_val;
            end else if (clr) begin
                flags_wr <= 1'b1;
                flags_wdata <= 8'h20;
            end
        end
    end
endmodule : isr_model

// ---- test_free_run_output_compare.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_free_run_output_compare import frc_pkg::*; ;
    logic clk = 0, rst = 1, load = 0, clr = 0, svc_en = 0, mask_wr = 0;
    logic global_mask = 1, compare_wr, flags_wr, compare_match, irq_req;
    logic [15:0] load_val = 16'h0000, compare_wdata, free_run_count, cv, c;
    logic [7:0] mask_wdata = 8'h00, flags_wdata, enm, flg;
    int n_fail = 0, samples_checked = 0;
    // Device with a short prescaler, and the processor model
    free_run_output_compare #(.DIV(4)) u_dut (.clk(clk), .rst(rst),
        .compare_wr(compare_wr), .compare_wdata(compare_wdata),
        .mask_wr(mask_wr), .mask_wdata(mask_wdata), .flags_wr(flags_wr),
        .flags_wdata(flags_wdata), .global_mask(global_mask),
        .free_run_count(free_run_count), .compare_three_value(cv),
        .timer_enable_mask(enm), .timer_event_flags(flg),
        .compare_match(compare_match), .irq_req(irq_req));
    isr_model u_cpu (.clk(clk), .rst(rst), .load(load), .load_val(load_val),
        .clr(clr), .svc_en(svc_en), .irq_req(irq_req),
        .compare_three_value(cv), .compare_wr(compare_wr),
        .compare_wdata(compare_wdata), .flags_wr(flags_wr),
        .flags_wdata(flags_wdata));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic summarize;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wait_match(input int lim);
        for (int i = 0; i < lim && compare_match !== 1'b1; i++) cyc(1);
        if (compare_match !== 1'b1) begin
            `CHK("match wait", 1'b1, compare_match)
            summarize();
        end
    endtask : wait_match
    task automatic pulse(input int which, input logic [15:0] v);
        @(posedge clk);
        if (which == 0) begin load <= 1; load_val <= v; end
        else if (which == 1) clr <= 1;
        else begin mask_wr <= 1; mask_wdata <= v[7:0]; end
        @(posedge clk);
        load <= 0; clr <= 0; mask_wr <= 0;
        cyc(2);
    endtask : pulse
    task automatic t_basic;
        `CHK("reset cmp", COMPARE_RST, cv)
        c = free_run_count;
        cyc(16);
        `CHK("count", c + 16'h0004, free_run_count)
        c = free_run_count + 16'h0005;
        pulse(0, c);
        `CHK("cmp load", c, cv)
        wait_match(100);
        `CHK("match", c, free_run_count)
        cyc(2);
        `CHK("flag", 1'b1, flg[5])
        `CHK("flag byte", 8'h20, flg)
        `CHK("irq off", 1'b0, irq_req)
        pulse(2, 16'h0020);
        `CHK("enable", 8'h20, enm)
        `CHK("masked", 1'b0, irq_req)
        @(posedge clk) global_mask <= 0;
        cyc(3);
        `CHK("irq on", 1'b1, irq_req)
        pulse(1, 16'h0000);
        `CHK("flag clr", 1'b0, flg[5])
        `CHK("irq clr", 1'b0, irq_req)
        pulse(0, free_run_count - 16'h0001);
        for (int i = 0; i < 300; i++) begin
            `CHK("no late", 1'b0, compare_match)
            cyc(1);
        end
    endtask : t_basic
    task automatic t_service;
        c = free_run_count + 16'h000A;
        @(posedge clk) svc_en <= 1;
        pulse(0, c);
        for (int k = 0; k < 2; k++) begin
            wait_match(2100);
            `CHK("svc match", c, free_run_count)
            cyc(8);
            `CHK("next cmp", c + 16'h01F4, cv)
            `CHK("svc flag", 1'b0, flg[5])
            c = c + 16'h01F4;
        end
        pulse(2, 16'h0000);
        `CHK("enable off", 8'h00, enm)
        wait_match(2100);
        `CHK("off match", c, free_run_count)
        cyc(4);
        `CHK("disabled", 1'b0, irq_req)
        `CHK("flag kept", 1'b1, flg[5])
        `CHK("no svc", c, cv)
    endtask : t_service
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        cyc(2);
        t_basic();
        t_service();
        summarize();
    end
endmodule : test_free_run_output_compare
